// file: shared/sfr_pkg.sv
/*
 * Shared constants and types for the special function register file:
 * data memory map, status and interrupt control fields, reset values,
 * operation codes, engine states and the request carriers.
 * Assumes an 8-bit data memory whose special area starts at 00H.
 */
`default_nettype none

package sfr_pkg;

	// data memory map, 7-bit offsets within a bank
	localparam logic [6:0] ADDR_IND0    = 7'h00;
	localparam logic [6:0] ADDR_MP0     = 7'h01;
	localparam logic [6:0] ADDR_IND1    = 7'h02;
	localparam logic [6:0] ADDR_MP1     = 7'h03;
	localparam logic [6:0] ADDR_BANK    = 7'h04;
	localparam logic [6:0] ADDR_ACC     = 7'h05;
	localparam logic [6:0] ADDR_PCL     = 7'h06;
	localparam logic [6:0] ADDR_TBLP    = 7'h07;
	localparam logic [6:0] ADDR_TABLE_HIGH_BYTE    = 7'h08;
	localparam logic [6:0] ADDR_TABLE_POINTER_HIGH    = 7'h09;
	localparam logic [6:0] ADDR_STATUS  = 7'h0A;
	localparam logic [6:0] ADDR_INTERRUPT_CONTROL_REG    = 7'h0B;
	localparam logic [6:0] ADDR_GP_BASE = 7'h20;

	// apb word index of the configuration register
	localparam logic [9:0] CFG_INDEX    = 10'h100;

	// status field positions
	localparam int ST_C   = 0;
	localparam int ST_AC  = 1;
	localparam int ST_Z   = 2;
	localparam int ST_OV  = 3;
	localparam int ST_PDF = 4;
	localparam int ST_TO  = 5;

	// interrupt control field positions
	localparam int IC_MASTER = 0;

	// reset values and the last program page
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [5:0] RST_STATUS = 6'h00;
	localparam logic [3:0] RST_INTERRUPT_CONTROL_REG   = 4'h0;
	localparam logic [3:0] LAST_PAGE  = 4'hF;

	typedef enum logic [3:0] {
		OP_READ, OP_WRITE, OP_LOAD, OP_ADD, OP_SUB,
		OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC
	} op_e;

	typedef enum logic [1:0] {
		ENG_IDLE, ENG_FETCH, ENG_FINISH, ENG_TABLE
	} eng_e;

	typedef struct packed {
		op_e        op;
		logic [6:0] addr;
	} core_req_s;

	typedef struct packed {
		logic       lastPage;
		logic [6:0] dest;
	} tbl_req_s;

	typedef struct packed {
		logic haltInstr;
		logic watchdogClearInstr;
		logic watchdogTimeout;
		logic irqEnter;
		logic interruptReturnInstr;
	} sys_evt_s;

endpackage

`default_nettype wire

// file: rtl/gp_ram.sv
/*
 * General purpose data memory array with registered read data.
 * Assumes one access per cycle; write and read share the address.
 */
`default_nettype none

module gp_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

`default_nettype wire

// file: rtl/special_function_register_file.sv
/*
 * Special function register area of an 8-bit controller's data memory,
 * with the general purpose RAM behind it, an APB slave view of the same
 * space, table read sequencing, status flags and the master interrupt
 * enable. Assumes the execution core keeps one request outstanding and
 * that program memory answers in the same cycle its address is presented.
 */
`default_nettype none

// Overview of operation
// - unused special locations read as zero
// - special registers start at data address zero
// - indirect ports redirect to paired pointer address
// - first pair bank 0, second pair all banks
// - indirect port via pointer: read zero, no write
// - memory pointers are ordinary read/write registers
// - low counter write jumps in page, dummy cycle
// - alu results land in accumulator; writes from it
// - table read: high part to table high byte
// - current-page table uses pointer high when enabled
// - last-page table read uses final program page
// - every table read is acknowledged four cycles after it is taken
// - status register is 8 bits with six flags
// - software status write keeps halt and watchdog flags
// - carry from add, no-borrow, rotate through carry
// - half carry from low nibble
// - zero flag follows zero result
// - overflow when carry in and out of msb differ
// - halt flag: set by halt, cleared by clear
// - watchdog flag: set on timeout, cleared by clear or halt
// - interrupt entry and calls never push status
// - master enable gates every individual enable
// - master enable cleared on entry, set on return
module special_function_register_file #(
	parameter int RAM_DEPTH = 256
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               coreValid,
	input  wire sfr_pkg::core_req_s coreReq,
	output logic                    coreReady,
	output logic                    coreAck,
	output logic [7:0]              coreRdata,
	input  wire logic               tblValid,
	input  wire sfr_pkg::tbl_req_s  tblReq,
	input  wire logic [11:0]        pcCur,
	output logic                    pcLoad,
	output logic [11:0]             pcTarget,
	output logic                    dummyCycle,
	output logic                    romReq,
	output logic [11:0]             romAddr,
	input  wire logic [14:0]        romData,
	input  wire sfr_pkg::sys_evt_s  evt,
	input  wire logic [2:0]         irqPending,
	output logic                    irqTake,
	output logic [7:0]              flagRegister,
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr
);
	import sfr_pkg::*;

	typedef struct packed {
		eng_e        st;
		op_e         op;
		logic        fromApb;
		logic [7:0]  ea;
		logic [7:0]  wdata;
		logic [7:0]  sfrCap;
		logic        isSfr;
		logic [7:0]  mp0;
		logic [7:0]  mp1;
		logic        bank;
		logic [7:0]  acc;
		logic [7:0]  tblp;
		logic [6:0]  table_high_byte;
		logic [3:0]  table_pointer_high;
		logic        tbhpEn;
		logic [5:0]  status;
		logic [3:0]  interrupt_control_reg;
		logic        coreReady;
		logic        coreAck;
		logic [7:0]  coreRdata;
		logic        pcLoad;
		logic [11:0] pcTarget;
		logic        dummyCycle;
		logic        romReq;
		logic [11:0] romAddr;
		logic        irqTake;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} regs_s;

	regs_s r;
	regs_s next_r;

	logic       ramWe;
	logic [7:0] ramRdata;

	////////////////////////////////////////////////////////////////////
	// address resolution and special register read mux

	function automatic logic [7:0] resolve(input logic [6:0] a,
			input logic b);
		logic [7:0] ea;
		ea = {b, a};
		if (a == ADDR_IND0) begin
			ea = {1'b0, r.mp0[6:0]};
		end else if (a == ADDR_IND1) begin
			ea = {r.bank, r.mp1[6:0]};
		end
		return ea;
	endfunction

	function automatic logic [7:0] sfrRead(input logic [6:0] a);
		logic [7:0] v;
		v = RST_BYTE;
		unique case (a)
			ADDR_MP0:    v = r.mp0;
			ADDR_MP1:    v = r.mp1;
			ADDR_BANK:   v = {7'h00, r.bank};
			ADDR_ACC:    v = r.acc;
			ADDR_PCL:    v = pcCur[7:0];
			ADDR_TBLP:   v = r.tblp;
			ADDR_TABLE_HIGH_BYTE:   v = {1'b0, r.table_high_byte};
			ADDR_TABLE_POINTER_HIGH:   v = {4'h0, r.table_pointer_high};
			ADDR_STATUS: v = {2'b00, r.status};
			ADDR_INTERRUPT_CONTROL_REG:   v = {4'h0, r.interrupt_control_reg};
			default:     v = RST_BYTE;
		endcase
		return v;
	endfunction

	logic       apbAccess;
	logic [9:0] apbIndex;
	logic       isSfrFetch;
	logic       writeOp;
	logic [7:0] operand;
	logic [7:0] addB;
	logic       cin;
	logic [8:0] sum9;
	logic [4:0] sumLo;
	logic [7:0] sum7;
	logic [7:0] res;
	logic       setZ;

	assign apbAccess  = psel && penable && !r.pready;
	assign apbIndex   = paddr[11:2];
	assign isSfrFetch = r.ea[6:0] < ADDR_GP_BASE;
	assign writeOp    = r.op == OP_WRITE;
	assign ramWe      = r.st == ENG_FETCH && writeOp && !isSfrFetch;
	assign operand    = r.isSfr ? r.sfrCap : ramRdata;

	// shared adder: subtraction is a plus inverted operand plus one
	assign cin   = r.op == OP_SUB;
	assign addB  = cin ? ~operand : operand;
	assign sum9  = {1'b0, r.acc} + {1'b0, addB} + {8'h00, cin};
	assign sumLo = {1'b0, r.acc[3:0]} + {1'b0, addB[3:0]} + {4'h0, cin};
	assign sum7  = {1'b0, r.acc[6:0]} + {1'b0, addB[6:0]} + {7'h00, cin};

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_r = r;
		next_r.coreAck = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		next_r.pcLoad = 1'b0;
		next_r.romReq = 1'b0;
		next_r.dummyCycle = r.pcLoad;
		res = r.acc;
		setZ = 1'b0;
		unique case (r.st)
			ENG_IDLE: begin
				if (r.coreReady && coreValid) begin
					next_r.op = coreReq.op;
					next_r.fromApb = 1'b0;
					next_r.ea = resolve(coreReq.addr, 1'b0);
					next_r.wdata = r.acc;
					next_r.st = ENG_FETCH;
				end else if (r.coreReady && tblValid) begin
					next_r.fromApb = 1'b0;
					next_r.ea = resolve(tblReq.dest, 1'b0);
					next_r.romReq = 1'b1;
					if (tblReq.lastPage) begin
						next_r.romAddr = {LAST_PAGE, r.tblp};
					end else if (r.tbhpEn) begin
						next_r.romAddr = {r.table_pointer_high, r.tblp};
					end else begin
						next_r.romAddr = {pcCur[11:8], r.tblp};
					end
					next_r.st = ENG_TABLE;
				end else if (apbAccess && apbIndex < CFG_INDEX) begin
					next_r.op = pwrite ? OP_WRITE : OP_READ;
					next_r.fromApb = 1'b1;
					next_r.ea = resolve(apbIndex[6:0], apbIndex[7]);
					next_r.wdata = pwdata[7:0];
					next_r.st = ENG_FETCH;
				end else if (apbAccess) begin
					next_r.pready = 1'b1;
					next_r.prdata = 32'h0000_0000;
					if (apbIndex == CFG_INDEX) begin
						if (pwrite) begin
							next_r.tbhpEn = pwdata[0];
						end else begin
							next_r.prdata = {31'h0000_0000, r.tbhpEn};
						end
					end else begin
						next_r.pslverr = 1'b1;
					end
				end
			end
			ENG_TABLE: begin
				next_r.table_high_byte = romData[14:8];
				next_r.wdata = romData[7:0];
				next_r.op = OP_WRITE;
				next_r.st = ENG_FETCH;
			end
			ENG_FETCH: begin
				next_r.isSfr = isSfrFetch;
				next_r.sfrCap = sfrRead(r.ea[6:0]);
				if (writeOp && isSfrFetch) begin
					unique case (r.ea[6:0])
						ADDR_MP0:  next_r.mp0 = r.wdata;
						ADDR_MP1:  next_r.mp1 = r.wdata;
						ADDR_BANK: next_r.bank = r.wdata[0];
						ADDR_ACC:  next_r.acc = r.wdata;
						ADDR_PCL: begin
							next_r.pcLoad = 1'b1;
							next_r.pcTarget = {pcCur[11:8], r.wdata};
						end
						ADDR_TBLP: next_r.tblp = r.wdata;
						ADDR_TABLE_POINTER_HIGH: next_r.table_pointer_high = r.wdata[3:0];
						ADDR_STATUS: begin
							next_r.status[ST_OV:ST_C] = r.wdata[3:0];
						end
						ADDR_INTERRUPT_CONTROL_REG: next_r.interrupt_control_reg = r.wdata[3:0];
						default: begin
							// indirect ports, table high byte, reserved
							next_r.st = ENG_FINISH;
						end
					endcase
				end
				next_r.st = ENG_FINISH;
			end
			ENG_FINISH: begin
				unique case (r.op)
					OP_LOAD: begin
						res = operand;
						setZ = 1'b1;
					end
					OP_ADD, OP_SUB: begin
						res = sum9[7:0];
						setZ = 1'b1;
						next_r.status[ST_C] = sum9[8];
						next_r.status[ST_AC] = sumLo[4];
						next_r.status[ST_OV] = sum7[7] ^ sum9[8];
					end
					OP_AND: begin
						res = r.acc & operand;
						setZ = 1'b1;
					end
					OP_OR: begin
						res = r.acc | operand;
						setZ = 1'b1;
					end
					OP_XOR: begin
						res = r.acc ^ operand;
						setZ = 1'b1;
					end
					OP_RLC: begin
						res = {operand[6:0], r.status[ST_C]};
						next_r.status[ST_C] = operand[7];
					end
					OP_RRC: begin
						res = {r.status[ST_C], operand[7:1]};
						next_r.status[ST_C] = operand[0];
					end
					default: res = r.acc;
				endcase
				if (r.op != OP_READ && r.op != OP_WRITE) begin
					next_r.acc = res;
				end
				if (setZ) begin
					next_r.status[ST_Z] = res == 8'h00;
				end
				if (r.fromApb) begin
					next_r.pready = 1'b1;
					next_r.prdata = writeOp ? 32'h0000_0000
						: {24'h00_0000, operand};
				end else begin
					next_r.coreAck = 1'b1;
					next_r.coreRdata = writeOp ? RST_BYTE : operand;
				end
				next_r.st = ENG_IDLE;
			end
		endcase
		next_r.coreReady = next_r.st == ENG_IDLE;

		// system flags: software writes above never reach them
		if (evt.watchdogClearInstr) begin
			next_r.status[ST_PDF] = 1'b0;
			next_r.status[ST_TO] = 1'b0;
		end
		if (evt.haltInstr) begin
			next_r.status[ST_PDF] = 1'b1;
			next_r.status[ST_TO] = 1'b0;
		end
		if (evt.watchdogTimeout) begin
			next_r.status[ST_TO] = 1'b1;
		end

		// entry only touches the enable; status is left to software
		if (evt.interruptReturnInstr) begin
			next_r.interrupt_control_reg[IC_MASTER] = 1'b1;
		end
		if (evt.irqEnter) begin
			next_r.interrupt_control_reg[IC_MASTER] = 1'b0;
		end
		next_r.irqTake = r.interrupt_control_reg[IC_MASTER]
			&& |(r.interrupt_control_reg[3:1] & irqPending);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.st <= ENG_IDLE;
			r.status <= RST_STATUS;
			r.interrupt_control_reg <= RST_INTERRUPT_CONTROL_REG;
		end else begin
			r <= next_r;
		end
	end

	gp_ram #(
		.WIDTH (8),
		.DEPTH (RAM_DEPTH),
		.AW    (8)
	) u_ram (
		.clk   (clk),
		.we    (ramWe),
		.addr  (r.ea),
		.wdata (r.wdata),
		.rdata (ramRdata)
	);

	assign coreReady    = r.coreReady;
	assign coreAck      = r.coreAck;
	assign coreRdata    = r.coreRdata;
	assign pcLoad       = r.pcLoad;
	assign pcTarget     = r.pcTarget;
	assign dummyCycle   = r.dummyCycle;
	assign romReq       = r.romReq;
	assign romAddr      = r.romAddr;
	assign irqTake      = r.irqTake;
	assign flagRegister = {2'b00, r.status};
	assign prdata       = r.prdata;
	assign pready       = r.pready;
	assign pslverr      = r.pslverr;

	////////////////////////////////////////////////////////////////////
	// checks

	chk_reserved_zero: assert property (@(posedge clk)
		disable iff (srst)
		(coreReady && coreValid && coreReq.op == OP_READ
			&& coreReq.addr >= 7'h0C && coreReq.addr < ADDR_GP_BASE)
		|-> ##3 (coreAck && coreRdata == 8'h00))
		else $error("reserved location did not read zero");

	chk_indirect_self: assert property (@(posedge clk)
		disable iff (srst)
		(coreReady && coreValid && coreReq.op == OP_READ
			&& coreReq.addr == ADDR_IND0
			&& (r.mp0[6:0] == ADDR_IND0 || r.mp0[6:0] == ADDR_IND1))
		|-> ##3 (coreAck && coreRdata == 8'h00))
		else $error("indirect read of a port was not zero");

	chk_pcl_dummy: assert property (@(posedge clk) disable iff (srst)
		pcLoad |=> dummyCycle && !pcLoad)
		else $error("low counter write lacked a dummy cycle");

	chk_table_cycles: assert property (@(posedge clk) disable iff (srst)
		(coreReady && !coreValid && tblValid)
		|-> ##1 (romReq && !coreAck) ##2 !coreAck ##1 coreAck)
		else $error("table read did not finish on time");

	chk_last_page: assert property (@(posedge clk) disable iff (srst)
		(coreReady && !coreValid && tblValid && tblReq.lastPage)
		|=> romAddr[11:8] == LAST_PAGE && romAddr[7:0] == $past(r.tblp))
		else $error("last page table address wrong");

	chk_keep_system: assert property (@(posedge clk) disable iff (srst)
		(r.st == ENG_FETCH && writeOp && r.ea[6:0] == ADDR_STATUS
			&& evt == '0)
		|=> $stable(r.status[ST_TO:ST_PDF]))
		else $error("status write changed system flags");

	chk_halt_flag: assert property (@(posedge clk) disable iff (srst)
		(evt.haltInstr && !evt.watchdogTimeout)
		|=> flagRegister[ST_PDF] && !flagRegister[ST_TO])
		else $error("halt did not set halt flag");

	chk_timeout_set: assert property (@(posedge clk) disable iff (srst)
		evt.watchdogTimeout |=> flagRegister[ST_TO])
		else $error("watchdog timeout flag not set");

	chk_master_entry: assert property (@(posedge clk) disable iff (srst)
		evt.irqEnter |=> !r.interrupt_control_reg[IC_MASTER] ##1 !irqTake)
		else $error("master enable not cleared on entry");

	chk_zero_flag: assert property (@(posedge clk) disable iff (srst)
		(coreAck && r.op inside {OP_ADD, OP_SUB, OP_AND, OP_OR,
			OP_XOR, OP_LOAD}) |-> flagRegister[ST_Z] == (r.acc == 8'h00))
		else $error("zero flag does not follow result");

endmodule

`default_nettype wire

// file: bench/rom_model.sv
/*
 * Program memory seen by the table read sequencer.
 * Assumes romData is sampled in the cycle romReq is high; outside that cycle
 * the word is meaningless and shown as a pattern that changes every cycle.
 */
`default_nettype none

module rom_model (
	input  wire logic        clk,
	input  wire logic        romReq,
	input  wire logic [11:0] romAddr,
	output logic      [14:0] romData
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [14:0] junk = 15'h2A55;

	always @(posedge clk) begin
		junk <= ~junk + 15'h0013;
	end

	// word stored at each address, low byte scrambled
	assign romData = romReq ? {romAddr[10:4], romAddr[7:0] ^ 8'hA5} : junk;
endmodule

`default_nettype wire

// file: bench/testbench.sv
/*
 * Self-checking bench for the special function register file.
 * Assumes the rom model answers table reads and the bench plays the
 * execution core, the event sources and the APB master.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_pkg::*;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        coreValid, tblValid, psel, penable, pwrite;
	core_req_s   coreReq;
	tbl_req_s    tblReq;
	sys_evt_s    evt;
	logic [11:0] pcCur, paddr, pcTarget, romAddr, tgt;
	logic [2:0]  irqPending;
	logic [31:0] pwdata, prdata, rw;
	logic        coreReady, coreAck, pcLoad, dummyCycle, romReq, irqTake;
	logic        pready, pslverr, err, pcSeen, dumOk, prevLoad;
	logic [7:0]  coreRdata, flagRegister, rd;
	logic [14:0] romData;
	logic [3:0]  fl;
	int          nMismatch = 0;
	int          samplesChecked = 0;

	always #10 clk = ~clk;

	special_function_register_file #(.RAM_DEPTH(256)) i_dut (
		.clk(clk), .srst(srst), .coreValid(coreValid), .coreReq(coreReq),
		.coreReady(coreReady), .coreAck(coreAck), .coreRdata(coreRdata),
		.tblValid(tblValid), .tblReq(tblReq), .pcCur(pcCur),
		.pcLoad(pcLoad), .pcTarget(pcTarget), .dummyCycle(dummyCycle),
		.romReq(romReq), .romAddr(romAddr), .romData(romData), .evt(evt),
		.irqPending(irqPending), .irqTake(irqTake),
		.flagRegister(flagRegister), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr)
	);

	rom_model i_rom (
		.clk(clk), .romReq(romReq), .romAddr(romAddr), .romData(romData)
	);

	// jump pulse and the dummy cycle right behind it
	always @(posedge clk) begin
		if (pcLoad) begin
			pcSeen <= 1'b1;
			tgt <= pcTarget;
		end
		if (dummyCycle && prevLoad)
			dumOk <= 1'b1;
		prevLoad <= pcLoad;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (nMismatch == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] wd, output logic [31:0] rdv,
			output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		e = pslverr;
		if (n >= 50)
			nMismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, {2'b00, idx, 2'b00}, {24'h0, v}, rw, err);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b0, {2'b00, idx, 2'b00}, 32'h0, rw, err);
		check({err, rw}, {1'b0, 24'h0, v});
	endtask

	// returns the number of edges from taken to acknowledge sampled
	task automatic req(input logic tbl, input op_e op, input logic [6:0] a,
			output int n);
		@(posedge clk);
		coreValid <= !tbl;
		tblValid <= tbl;
		coreReq <= '{op: op, addr: a};
		do @(posedge clk); while (coreReady !== 1'b1);
		coreValid <= 1'b0;
		tblValid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (coreAck !== 1'b1 && n < 20);
		rd = coreRdata;
		if (n >= 20)
			nMismatch++;
	endtask

	task automatic pulse(input sys_evt_s e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask

	function automatic logic [11:0] alu(op_e op, logic [7:0] a, b,
			logic [3:0] f);
		logic [7:0] bb;
		logic [8:0] s;
		logic [4:0] h;
		logic       ci;
		ci = (op == OP_SUB);
		bb = ci ? ~b : b;
		s = a + bb + ci;
		h = a[3:0] + bb[3:0] + ci;
		case (op)
			OP_ADD, OP_SUB: begin
				f = {(a[7] == bb[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
					h[4], s[8]};
				return {f, s[7:0]};
			end
			OP_RLC: return {f[3:1], b[7], b[6:0], f[0]};
			OP_RRC: return {f[3:1], b[0], f[0], b[7:1]};
			OP_AND: s[7:0] = a & b;
			OP_OR: s[7:0] = a | b;
			OP_XOR: s[7:0] = a ^ b;
			default: s[7:0] = b;
		endcase
		f[2] = (s[7:0] == 8'h00);
		return {f, s[7:0]};
	endfunction

	task automatic t_map();
		int n;
		check(flagRegister, 8'h00);
		rdchk(8'h0C, 8'h00);
		apb(1'b0, 12'h404, 32'h0, rw, err);
		check({err, rw}, {1'b1, 32'h0});
		wr(8'h01, 8'h21);
		wr(8'h21, 8'h5A);
		rdchk(8'h01, 8'h21);
		req(1'b0, OP_READ, 7'h00, n);
		check(rd, 8'h5A);
		req(1'b0, OP_READ, 7'h0C, n);
		check(rd, 8'h00);
		wr(8'h01, 8'h00);
		req(1'b0, OP_READ, 7'h00, n);
		check(rd, 8'h00);
		wr(8'hA1, 8'h33);
		wr(8'h03, 8'h21);
		wr(8'h04, 8'h01);
		wr(8'h01, 8'h21);
		req(1'b0, OP_READ, 7'h02, n);
		check(rd, 8'h33);
		req(1'b0, OP_READ, 7'h00, n);
		check(rd, 8'h5A);
		check(n, 3);
		wr(8'h04, 8'h00);
	endtask

	task automatic t_alu();
		op_e        ops [10] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB,
			OP_SUB, OP_AND, OP_XOR, OP_RLC, OP_RRC};
		logic [7:0] av [10] = '{8'h0F, 8'h7F, 8'hFF, 8'h10, 8'h80, 8'h01,
			8'hF0, 8'h3C, 8'h00, 8'h00};
		logic [7:0] bv [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02,
			8'h0F, 8'h3C, 8'h81, 8'h03};
		logic [11:0] e;
		int n;
		wr(8'h0A, 8'h00);
		fl = 4'h0;
		for (int i = 0; i < 10; i++) begin
			wr(8'h23, av[i]);
			wr(8'h22, bv[i]);
			req(1'b0, OP_LOAD, 7'h23, n);
			e = alu(OP_LOAD, 8'h00, av[i], fl);
			req(1'b0, ops[i], 7'h22, n);
			e = alu(ops[i], av[i], bv[i], e[11:8]);
			fl = e[11:8];
			check(flagRegister, {4'h0, fl});
			req(1'b0, OP_WRITE, 7'h25, n);
			rdchk(8'h25, e[7:0]);
		end
	endtask

	task automatic t_status();
		pulse('{watchdogTimeout: 1'b1, default: 1'b0});
		pulse('{haltInstr: 1'b1, default: 1'b0});
		check(flagRegister[5:4], 2'b01);
		pulse('{watchdogTimeout: 1'b1, default: 1'b0});
		wr(8'h0A, 8'hFF);
		rdchk(8'h0A, 8'h3F);
		wr(8'h0A, 8'h00);
		check(flagRegister, 8'h30);
		pulse('{watchdogClearInstr: 1'b1, default: 1'b0});
		check(flagRegister, 8'h00);
	endtask

	task automatic t_jump();
		int n;
		pcCur <= 12'h3A7;
		wr(8'h23, 8'h5A);
		req(1'b0, OP_LOAD, 7'h23, n);
		req(1'b0, OP_WRITE, 7'h06, n);
		repeat (2) @(posedge clk);
		check({pcSeen, dumOk, tgt}, {2'b11, 12'h35A});
	endtask

	task automatic t_table();
		logic [11:0] a [3] = '{12'hF06, 12'h306, 12'h206};
		int n;
		wr(8'h07, 8'h06);
		wr(8'h09, 8'h02);
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				apb(1'b1, 12'h400, 32'h1, rw, err);
			tblReq <= '{lastPage: (i == 0), dest: 7'h24};
			req(1'b1, OP_READ, 7'h00, n);
			check(n, 4);
			check(romAddr, a[i]);
			rdchk(8'h24, a[i][7:0] ^ 8'hA5);
			rdchk(8'h08, {1'b0, a[i][10:4]});
		end
	endtask

	task automatic t_irq();
		logic [7:0] f;
		f = flagRegister;
		irqPending <= 3'b010;
		wr(8'h0B, 8'h05);
		repeat (3) @(posedge clk);
		check(irqTake, 1'b1);
		wr(8'h0B, 8'h04);
		repeat (3) @(posedge clk);
		check(irqTake, 1'b0);
		wr(8'h0B, 8'h0F);
		pulse('{irqEnter: 1'b1, default: 1'b0});
		rdchk(8'h0B, 8'h0E);
		check(flagRegister, f);
		pulse('{interruptReturnInstr: 1'b1, default: 1'b0});
		rdchk(8'h0B, 8'h0F);
	endtask

	initial begin
		{coreValid, tblValid, psel, penable, pwrite} = '0;
		{pcSeen, dumOk, prevLoad} = '0;
		coreReq = '{op: OP_READ, addr: 7'h00};
		tblReq = '0;
		evt = '0;
		pcCur = 12'h000;
		irqPending = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		t_map();
		t_alu();
		t_status();
		t_jump();
		t_table();
		t_irq();
		print_verdict();
	end

	initial begin
		#200000;
		nMismatch++;
		print_verdict();
	end
endmodule

`default_nettype wire
